// >>> hdl/hsc_pkg.sv
`default_nettype none
package hsc_pkg;
   // ***************
   // timing
   // ***************
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned CYCLE_TIME_S = 5;
   localparam int unsigned CYCLE_CLKS   = CYCLE_TIME_S * CLK_HZ;
   // ***************
   // register byte addresses
   // ***************
   localparam logic [7:0] A_OPER   = 8'h00;
   localparam logic [7:0] A_CMD    = 8'h04;
   localparam logic [7:0] A_STOP   = 8'h08;
   localparam logic [7:0] A_CAPAB  = 8'h0C;
   localparam logic [7:0] A_STWORD = 8'h10;
   localparam logic [7:0] A_STIN   = 8'h14;
   localparam logic [7:0] A_STVOUT = 8'h18;
   localparam logic [7:0] A_STIOUT = 8'h1C;
   localparam logic [7:0] A_STTEMP = 8'h20;
   localparam logic [7:0] A_STMFR  = 8'h24;
   localparam logic [7:0] A_IDSEL  = 8'h28;
   localparam logic [7:0] A_IDDATA = 8'h2C;
   // ***************
   // fields, codes, reset values
   // ***************
   localparam int         OPER_ON_BIT = 7;
   localparam logic [7:0] OPER_RST    = 8'h80;
   localparam int         CMD_PEC_LSB = 16;
   localparam int         CMD_PEC_EN  = 24;
   localparam int         CMD_GROUP   = 25;
   localparam logic [7:0] C_OPER      = 8'h01;
   localparam logic [7:0] C_CLEAR     = 8'h03;
   localparam logic [7:0] C_CYCLE     = 8'hD9;
   localparam logic [7:0] CAPAB_VAL   = 8'hB0;
   // identity strings, values arbitrary
   localparam logic [31:0] ID_MFR   = 32'h4853_5750;
   localparam logic [31:0] ID_MODEL = 32'h4853_3031;
   localparam logic [31:0] ID_REV   = 32'h5231_4130;
   localparam logic [7:0]  ID_LEN   = 8'h04;
   // ***************
   // synchronised input and latch indices
   // ***************
   localparam int I_UV = 0, I_OV = 1, I_TMR = 2, I_GOOD = 3, I_EN = 4;
   localparam int I_CUR = 5, I_OT = 6, I_FH = 7, I_WARN = 8, N_IN = 15;
   localparam int F_OC = 0, F_OV = 1, F_UV = 2, F_OT = 3, F_FH = 4;
   localparam int F_PEC = 5, W_VINOV = 6, W_VINUV = 7, W_VOUTOV = 8;
   localparam int W_VOUTUV = 9, W_IOC = 10, W_OT = 11, W_PWR = 12;
   localparam int N_LAT = 13;
   typedef enum logic [1:0] {
      HS_OFF   = 2'b00,
      HS_RAMP  = 2'b01,
      HS_GOOD  = 2'b10,
      HS_FAULT = 2'b11
   } hsc_hs_t;
endpackage : hsc_pkg
`default_nettype wire

// >>> hdl/hsc_top.sv
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: gate decided by hot swap state machine
// R2: undervoltage keeps gate off despite on request
// R3: cleared on request holds gate low
// R4: on request is bit 7, resets to 1
// R5: writing on bit 0 turns gate off
// R6: uv low or ov high: on bit irrelevant
// R7: status shows whether gate is enabled
// R8: on bit 0 then 1 clears faults, flag
// R9: power cycle: off five seconds, then on
// R10: capability reports speed, pec, alert support
// R11: id strings by block read with count
// R12: six status registers, summary byte and word
// R13: faults only from hot swap sources
// R14: fault: gate off, flag up, good down
// R15: warnings only alert, never touch gate
// R16: faults and warnings latch until cleared
// R17: word low byte equals byte, pointers high
// R18: input status: vin faults, warnings, overpower
// R19: vout, iout, temperature status contents
// R20: clear faults; active conditions set again
// R21: bad pec discards command, sets flag
// R22: group commands execute at stop
// R23: host sends clear faults without data
module hsc_top
   import hsc_pkg::*;
#(
   parameter int unsigned CYCLE_CLKS_P = CYCLE_CLKS
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // hot swap pins, asynchronous
   input  wire logic        undervoltage_input_i,
   input  wire logic        overvoltage_input_i,
   input  wire logic        oc_timer_expired_i,
   input  wire logic        output_good_sense_i,
   input  wire logic        enable_i,
   input  wire logic        current_limit_i,
   input  wire logic        overtemp_i,
   input  wire logic        fet_health_bad_i,
   // power monitor threshold results
   input  wire logic [6:0]  warn_i,
   // outputs
   output logic             fet_drive_o,
   output logic             error_flag_o,
   output logic             power_good_out_o,
   output logic [1:0]       multipurpose_outs_o
);
   // ***************
   // state
   // ***************
   typedef struct packed {
      logic [N_IN-1:0]  sync1;    // first synchroniser stage
      logic [N_IN-1:0]  sync2;    // second synchroniser stage
      logic             on_bit;   // host on request
      hsc_hs_t          hs;       // hot swap state
      logic [N_LAT-1:0] latch;    // latched faults and warnings
      logic             err;      // error flag output
      logic             fet;      // gate drive
      logic             pgood;    // power good
      logic [1:0]       mp;       // multipurpose outputs
      logic             cyc_act;  // power cycle running
      logic [29:0]      cyc_cnt;  // power cycle countdown
      logic             pend_v;   // held group command
      logic [7:0]       pend_c;   // held code
      logic [7:0]       pend_d;   // held data
      logic [1:0]       id_sel;   // selected id string
      logic [2:0]       id_ptr;   // block read pointer
      logic             ack;      // bus answer
      logic [31:0]      rdat;     // read data
   } hsc_state_t;

   hsc_state_t st;       // registered state
   hsc_state_t next_st;  // next state

   // ***************
   // helpers
   // ***************
   // smbus crc-8, polynomial x8+x2+x+1
   function automatic logic [7:0] hsc_crc8(input logic [7:0] c,
                                           input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      end
      return r;
   endfunction : hsc_crc8

   // block read bytes: count first, then ascii
   function automatic logic [7:0] hsc_id_byte(input logic [1:0] s,
                                              input logic [2:0] p);
      logic [39:0] w;  // count byte, then four characters
      w = {ID_LEN, ((s == 2'h0) ? ID_MFR : (s == 2'h1) ? ID_MODEL : ID_REV)};
      // pointer never passes the last character
      return w[8 * (4 - int'(p)) +: 8];
   endfunction : hsc_id_byte

   // ***************
   // combinational view
   // ***************
   logic [N_IN-1:0]  raw;       // pins gathered
   logic             allow;     // all gate permits present
   logic             hard;      // latch-off fault present
   logic [N_LAT-1:0] cond;      // live fault and warning causes
   logic             taken;     // bus request taken this edge
   logic             wr;        // write taken
   logic [31:0]      wdat;      // write data masked by lanes
   logic             pec_bad;   // pec mismatch on command write
   logic [7:0]       crc;       // computed pec
   logic             ex_v;      // execute a command now
   logic [7:0]       ex_c;      // its code
   logic [7:0]       ex_d;      // its data
   logic             toggle;    // on bit 0 to 1
   logic             clr_all;   // status clear this edge
   logic [7:0]       sbyte;     // summary byte
   logic [7:0]       shi;       // summary word high byte
   logic [7:0]       stin;      // input status
   logic [7:0]       stvout;    // output voltage status
   logic [7:0]       stiout;    // output current status
   logic [7:0]       sttemp;    // temperature status
   logic [7:0]       stmfr;     // device specific status

   assign raw = {warn_i, fet_health_bad_i, overtemp_i, current_limit_i,
                 enable_i, output_good_sense_i, oc_timer_expired_i,
                 overvoltage_input_i, undervoltage_input_i};

   // status views of the latches, then the next state
   always_comb begin
      stin   = {st.latch[F_OV], st.latch[W_VINOV], st.latch[W_VINUV],
                st.latch[F_UV], 3'h0, st.latch[W_PWR]};          // R18
      stvout = {1'b0, st.latch[W_VOUTOV], st.latch[W_VOUTUV], 5'h00}; // R19
      stiout = {st.latch[F_OC], 1'b0, st.latch[W_IOC], 5'h00};   // R19
      sttemp = {st.latch[F_OT], st.latch[W_OT], 6'h00};          // R19
      stmfr  = {6'h00, st.latch[F_PEC], st.latch[F_FH]};
      // off bit is live from the gate drive
      sbyte  = {1'b0, ~st.fet, 1'b0, st.latch[F_OC], st.latch[F_UV],
                st.latch[F_OT], st.latch[F_PEC], 1'b0};          // R7
      // pointers to detail registers, fet health, power good
      shi    = {|stvout, |stiout, |stin, |stmfr, ~st.pgood,
                st.latch[F_FH], 2'h0};                           // R17
      // next state starts as a copy of the present one
      next_st = st;
      // two-stage synchronisers
      next_st.sync1 = raw;
      next_st.sync2 = st.sync1;
      // live causes, faults from hot swap only
      cond = '0;
      cond[F_OC]  = st.sync2[I_CUR] & st.sync2[I_TMR];          // R13
      cond[F_OV]  = st.sync2[I_OV];                              // R13
      cond[F_UV]  = ~st.sync2[I_UV];                             // R13
      cond[F_OT]  = st.sync2[I_OT];                              // R13
      cond[F_FH]  = st.sync2[I_FH];                              // R13
      cond[W_PWR:W_VINOV] = st.sync2[I_WARN +: 7];               // R15
      // bus request decode
      taken = wb_cyc_i & wb_stb_i & ~st.ack;
      wr    = taken & wb_we_i;
      wdat  = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      crc   = hsc_crc8(8'h00, wdat[7:0]);
      // send-byte clear carries no data byte in its pec
      if (wdat[7:0] != C_CLEAR) begin
         crc = hsc_crc8(crc, wdat[15:8]);                        // R23
      end
      pec_bad = 1'b0;
      ex_v = 1'b0;
      ex_c = wdat[7:0];
      ex_d = wdat[15:8];
      if (wr && wb_adr_i == A_OPER) begin
         // direct operation write
         ex_v = 1'b1;
         ex_c = C_OPER;
         ex_d = wdat[7:0];
      end else if (wr && wb_adr_i == A_CMD) begin
         if (wdat[CMD_PEC_EN] && crc != wdat[CMD_PEC_LSB +: 8]) begin
            pec_bad = 1'b1;                                      // R21
         end else if (wdat[CMD_GROUP]) begin
            // hold until the stop
            next_st.pend_v = 1'b1;                               // R22
            next_st.pend_c = wdat[7:0];
            next_st.pend_d = wdat[15:8];
         end else begin
            ex_v = 1'b1;
         end
      end else if (wr && wb_adr_i == A_STOP && st.pend_v) begin
         ex_v = 1'b1;                                            // R22
         ex_c = st.pend_c;
         ex_d = st.pend_d;
         next_st.pend_v = 1'b0;
      end
      cond[F_PEC] = pec_bad;                                     // R21
      // command execution
      toggle = 1'b0;
      clr_all = 1'b0;
      if (ex_v) begin
         case (ex_c)
            C_OPER: begin
               next_st.on_bit = ex_d[OPER_ON_BIT];               // R4
               toggle = ~st.on_bit & ex_d[OPER_ON_BIT];          // R8
            end
            C_CLEAR: clr_all = 1'b1;                             // R20
            C_CYCLE: begin
               next_st.cyc_act = 1'b1;                           // R9
               next_st.cyc_cnt = 30'(CYCLE_CLKS_P - 1);
            end
            default: toggle = 1'b0;  // other codes are ignored
         endcase
      end
      clr_all = clr_all | toggle;
      // power cycle countdown, then on again unaided
      if (st.cyc_act && !(ex_v && ex_c == C_CYCLE)) begin
         if (st.cyc_cnt == 30'h0) begin
            next_st.cyc_act = 1'b0;                              // R9
         end else begin
            next_st.cyc_cnt = st.cyc_cnt - 30'h1;
         end
      end
      // latches: set wins over clear
      next_st.latch = (st.latch & ~{N_LAT{clr_all}}) | cond;    // R16 R20
      // error flag released only by the on toggle
      next_st.err = (st.err & ~toggle) | (|cond[F_FH:F_OC]);     // R8 R14
      // hot swap state machine
      allow = st.on_bit & st.sync2[I_UV] & ~st.sync2[I_OV]
              & st.sync2[I_EN] & ~st.cyc_act;                    // R2 R3 R6
      hard  = cond[F_OC] | cond[F_OT] | cond[F_FH];              // R14
      case (st.hs)
         HS_OFF: begin
            if (allow && !hard) begin
               next_st.hs = HS_RAMP;                             // R1
            end
         end
         HS_RAMP, HS_GOOD: begin
            if (hard) begin
               next_st.hs = HS_FAULT;                            // R14
            end else if (!allow) begin
               next_st.hs = HS_OFF;                              // R5
            end else begin
               // follow the output good sense while on
               next_st.hs = st.sync2[I_GOOD] ? HS_GOOD : HS_RAMP;
            end
         end
         HS_FAULT: begin
            // latch-off until faults are cleared
            if (clr_all) begin
               next_st.hs = HS_OFF;
            end
         end
         default: next_st.hs = HS_OFF;
      endcase
      next_st.fet   = (next_st.hs == HS_RAMP) | (next_st.hs == HS_GOOD); // R1
      next_st.pgood = (next_st.hs == HS_GOOD);                   // R14
      // pin two: any latched bit; pin one: warnings only
      next_st.mp = {|next_st.latch, |next_st.latch[W_PWR:W_VINOV]}; // R15
      // bus answer one cycle after the request is taken
      next_st.ack = taken;
      if (taken) begin
         if (wr && wb_adr_i == A_IDSEL) begin
            next_st.id_sel = wdat[1:0];
            next_st.id_ptr = 3'h0;
         end
         case (wb_adr_i)
            A_OPER:   next_st.rdat = {24'h0, st.on_bit, 7'h00};
            A_CAPAB:  next_st.rdat = {24'h0, CAPAB_VAL};         // R10
            A_STWORD: next_st.rdat = {16'h0, shi, sbyte};        // R12 R17
            A_STIN:   next_st.rdat = {24'h0, stin};              // R12
            A_STVOUT: next_st.rdat = {24'h0, stvout};            // R12
            A_STIOUT: next_st.rdat = {24'h0, stiout};            // R12
            A_STTEMP: next_st.rdat = {24'h0, sttemp};            // R12
            A_STMFR:  next_st.rdat = {24'h0, stmfr};             // R12
            A_IDSEL:  next_st.rdat = {30'h0, st.id_sel};
            A_IDDATA: begin
               next_st.rdat = {24'h0, hsc_id_byte(st.id_sel,
                                                  st.id_ptr)};   // R11
               if (!wb_we_i && st.id_ptr != 3'h4) begin
                  next_st.id_ptr = st.id_ptr + 3'h1;
               end
            end
            default:  next_st.rdat = 32'h0;
         endcase
      end
   end

   // ***************
   // registers
   // ***************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st        <= '0;
         st.on_bit <= OPER_RST[OPER_ON_BIT];                     // R4
         // supply reads sufficient until the pin has been sampled
         st.sync1[I_UV] <= 1'b1;
         st.sync2[I_UV] <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o            = st.rdat;
   assign wb_ack_o            = st.ack;
   assign fet_drive_o         = st.fet;
   assign error_flag_o        = st.err;
   assign power_good_out_o    = st.pgood;
   assign multipurpose_outs_o = st.mp;

   // ***************
   // assertions
   // ***************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_drive_needs_on: assert property (fet_drive_o |-> $past(st.on_bit)) // R3
      else $error("gate on without on request");
   a_uv_keeps_off: assert property (!$past(st.sync2[I_UV]) |-> !fet_drive_o) // R2
      else $error("gate on under undervoltage");
   a_ov_keeps_off: assert property ($past(st.sync2[I_OV]) |-> !fet_drive_o) // R6
      else $error("gate on under overvoltage");
   a_off_write: assert property ($fell(st.on_bit) |=> !fet_drive_o) // R5
      else $error("gate stayed on after off write");
   a_reset_on: assert property ($past(rst_i) |-> st.on_bit) // R4
      else $error("on bit not set after reset");
   a_off_status: assert property (taken && wb_adr_i == A_STWORD |=>
                                  wb_dat_o[6] == !$past(fet_drive_o)) // R7
      else $error("off status disagrees with gate");
   a_word_low: assert property (taken && wb_adr_i == A_STWORD |=>
                                wb_dat_o[7:0] == $past(sbyte)) // R17
      else $error("word low byte differs from byte");
   a_toggle_clears: assert property (toggle && !(|cond[F_FH:F_OC])
                                     |=> !error_flag_o) // R8
      else $error("toggle did not release flag");
   a_fault_flag: assert property (hard |=> error_flag_o &&
                                  !power_good_out_o ##1 !fet_drive_o) // R14
      else $error("fault not acted on");
   a_latch_hold: assert property (!clr_all |=>
                     (st.latch & $past(st.latch)) == $past(st.latch)) // R16
      else $error("latched bit lost without clear");
   a_clear_set: assert property (clr_all |=> st.latch == $past(cond)) // R20
      else $error("clear result wrong");
   a_pec_drop: assert property (pec_bad |=> st.latch[F_PEC] &&
                                $stable(st.on_bit) && !st.pend_v ||
                                $past(st.pend_v)) // R21
      else $error("bad pec not discarded");
   a_group_held: assert property (wr && wb_adr_i == A_CMD && !pec_bad &&
                                  wdat[CMD_GROUP] |=> st.pend_v &&
                                  $stable(st.on_bit)) // R22
      else $error("group command not held");
   a_cycle_off: assert property (ex_v && ex_c == C_CYCLE
                                 |=> ##1 !fet_drive_o [*8]) // R9
      else $error("power cycle did not hold gate off");

   c_gate_on:  cover property ($rose(fet_drive_o));
   c_pec_bad:  cover property (pec_bad);
   c_cycle:    cover property (ex_v && ex_c == C_CYCLE);
   c_toggle:   cover property (toggle);
endmodule : hsc_top
`default_nettype wire

// >>> verif/hsc_host.sv
`timescale 1ns/100ps
`default_nettype none
// ***************
// bus host model: classic wishbone single cycles
// ***************
module hsc_host (
   // clock
   input  wire logic        clk_i,
   // answer from the block
   input  wire logic        wb_ack_i,
   input  wire logic [31:0] wb_dat_i,
   // request to the block
   output var  logic        wb_cyc_o,
   output var  logic        wb_stb_o,
   output var  logic        wb_we_o,
   output var  logic [7:0]  wb_adr_o,
   output var  logic [31:0] wb_dat_o
);
   // idle bus at time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'h00;
      wb_dat_o = 32'h0000_0000;
   end
   // one access: hold until ack is sampled high, then release
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= w;
      wb_adr_o <= a;
      wb_dat_o <= d;
      // wait for the answer; only the bench watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_i !== 1'b1);
      q = wb_dat_i;
      // released data shows the inverse so stale values never match
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~d;
      @(posedge clk_i);
   endtask : bus
endmodule : hsc_host
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import hsc_pkg::*;
   localparam int unsigned CYC = 50; // shortened power cycle
   logic clk_i, rst_i, cyc, stb, we, ack, fet, eflag, pgood;
   logic uv, ov, tmr, good, en, cur, ot, fh;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [6:0]  warn;
   logic [1:0]  mpo;
   int num_errors = 0, num_checks = 0, n;
   // ***************
   // clock, watchdog, instances
   // ***************
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      #400000;
      num_errors++;
      complete_run();
   end
   hsc_host host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
      .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
      .wb_dat_o(wdat));
   hsc_top #(.CYCLE_CLKS_P(CYC)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
      .undervoltage_input_i(uv), .overvoltage_input_i(ov),
      .oc_timer_expired_i(tmr), .output_good_sense_i(good),
      .enable_i(en), .current_limit_i(cur), .overtemp_i(ot),
      .fet_health_bad_i(fh), .warn_i(warn), .fet_drive_o(fet),
      .error_flag_o(eflag), .power_good_out_o(pgood),
      .multipurpose_outs_o(mpo));
   // ***************
   // helpers
   // ***************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      host.bus(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask : rd
   task automatic settle();
      repeat (6) @(posedge clk_i);
   endtask : settle
   task automatic toggle_on(); // on bit 0 then 1 clears latches
      wr(A_OPER, 32'h0000_0000);
      wr(A_OPER, 32'h0000_0080);
      settle();
   endtask : toggle_on
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc8
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   // ***************
   // main sequence
   // ***************
   initial begin
      {uv, good, en} = 3'b111;
      {ov, tmr, cur, ot, fh} = 5'b00000;
      warn  = 7'h00;
      rst_i = 1'b1;
      void'($urandom(32'hBAB5));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(A_OPER, 32'h0000_0080);
      rd(A_CAPAB, {24'h0, CAPAB_VAL});
      rd(8'h30, 32'h0000_0000);
      chk({fet, eflag, mpo}, 4'h8);
      toggle_on();
      chk(fet, 1'b1);
      chk(eflag, 1'b0);
      $display("test reset done");
      // host off request, then back on
      wr(A_OPER, 32'h0000_0000);
      settle();
      chk(fet, 1'b0);
      rd(A_STWORD, 32'h0000_0840);
      wr(A_OPER, 32'h0000_0080);
      settle();
      chk(fet, 1'b1);
      // undervoltage: fault latches, gate stays off
      @(posedge clk_i) uv <= 1'b0;
      settle();
      wr(A_OPER, 32'h0000_0080);
      settle();
      chk({fet, eflag, pgood}, 3'b010);
      chk(mpo[1], 1'b1);
      @(posedge clk_i) uv <= 1'b1;
      settle();
      rd(A_STIN, 32'h0000_0010);
      wr(A_CMD, {24'h0, C_CLEAR});
      rd(A_STIN, 32'h0000_0000);
      chk(eflag, 1'b1);
      toggle_on();
      chk(eflag, 1'b0);
      // clearing while the condition stays sets it again
      @(posedge clk_i) uv <= 1'b0;
      settle();
      wr(A_CMD, {24'h0, C_CLEAR});
      rd(A_STIN, 32'h0000_0010);
      @(posedge clk_i) begin
         uv <= 1'b1;
         ov <= 1'b1;
      end
      settle();
      wr(A_OPER, 32'h0000_0080);
      settle();
      chk(fet, 1'b0);
      rd(A_STIN, 32'h0000_0090);
      @(posedge clk_i) ov <= 1'b0;
      toggle_on();
      chk(fet, 1'b1);
      $display("test voltage done");
      // latch-off faults: oc, overtemperature, fet health
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i) begin
            {tmr, cur} <= {2{k == 0}};
            ot <= (k == 1);
            fh <= (k == 2);
         end
         settle();
         chk({fet, eflag, pgood}, 3'b010);
         @(posedge clk_i) {tmr, cur, ot, fh} <= 4'h0;
         settle();
         chk(fet, 1'b0);
         if (k == 0) rd(A_STIOUT, 32'h0000_0080);
         if (k == 1) rd(A_STTEMP, 32'h0000_0080);
         if (k == 2) rd(A_STMFR, 32'h0000_0001);
         toggle_on();
         chk(fet, 1'b1);
      end
      $display("test faults done");
      // random warnings never touch the gate
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_i) warn <= (k == 0) ? 7'h7F : 7'($urandom);
         settle();
         chk({fet, mpo[0]}, {1'b1, |warn});
         rd(A_STIN, {24'h0, 1'b0, warn[0], warn[1], 4'h0, warn[6]});
         rd(A_STVOUT, {25'h0, warn[2], warn[3], 5'h0});
         rd(A_STIOUT, {26'h0, warn[4], 5'h0});
         rd(A_STTEMP, {25'h0, warn[5], 6'h0});
         host.bus(1'b0, A_STWORD, 32'h0, q);
         chk(q[15:13], {|warn[3:2], warn[4], |{warn[6], warn[1:0]}});
         @(posedge clk_i) warn <= 7'h00;
         settle();
         wr(A_CMD, {24'h0, C_CLEAR});
      end
      $display("test warnings done");
      // timed power cycle
      wr(A_CMD, {24'h0, C_CYCLE});
      for (n = 0; n < 10 && fet === 1'b1; n++) @(posedge clk_i);
      for (n = 0; n < 200 && fet !== 1'b1; n++) @(posedge clk_i);
      chk(n >= CYC - 1 && n <= CYC + 4, 1'b1);
      $display("test power cycle done");
      // bad check byte is dropped, good one executes
      wr(A_CMD, {7'h0, 1'b1, ~crc8(16'h0100), 16'h0001});
      settle();
      chk(fet, 1'b1);
      rd(A_STMFR, 32'h0000_0002);
      wr(A_CMD, {7'h0, 1'b1, crc8(16'h0100), 16'h0001});
      settle();
      chk(fet, 1'b0);
      toggle_on();
      // group command waits for stop
      wr(A_CMD, 32'h0200_0001);
      settle();
      chk(fet, 1'b1);
      wr(A_STOP, 32'h0000_0000);
      settle();
      chk(fet, 1'b0);
      toggle_on();
      $display("test commands done");
      // identity strings: count then characters
      for (int s = 0; s < 3; s++) begin
         wr(A_IDSEL, s);
         rd(A_IDDATA, {24'h0, ID_LEN});
         for (int c = 0; c < 4; c++) begin
            rd(A_IDDATA, ((s == 0 ? ID_MFR : s == 1 ? ID_MODEL
               : ID_REV) >> (24 - 8 * c)) & 32'hFF);
         end
      end
      $display("test identity done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
